// [core/usart_consts.svh]
// USART register offsets, reset values and bit-rate constants.
// Assumes byte addresses on a 32-bit Avalon-MM slave, data in lane 0.
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH
`define OFS_RX_CTRL     8'h18
`define OFS_TX_CTRL     8'h98
`define OFS_DIVISOR     8'h9C
`define OFS_PORT_DIR    8'hA0
`define OFS_TX_DATA     8'hA4
`define OFS_RX_DATA     8'hA8
`define OFS_STATUS      8'hAC
`define TX_CTRL_RST     8'h02
`define RX_CTRL_RST     8'h00
`define DIVISOR_RST     8'h00
`define PORT_DIR_RST    2'h3
`define TX_CTRL_WMASK   8'hF5
`define RX_CTRL_WMASK   8'hF0
`define TICKS_ASYNC_LO  7'h40
`define TICKS_ASYNC_HI  7'h10
`define TICKS_SYNC      7'h04
`define SCLK_RISE       2'h1
`define SCLK_FALL       2'h3
`define BITS_NARROW     4'h8
`define BITS_WIDE       4'h9
`endif

// [core/usart_pkg.sv]
// Types shared by the USART control block.
// Assumes the register layout of the constants header.
package usart_pkg;
    typedef enum logic [1:0] {
        LINK_IDLE  = 2'h0,
        LINK_START = 2'h1,
        LINK_DATA  = 2'h3,
        LINK_STOP  = 2'h2
    } link_state_e;
    typedef struct packed {
        logic clock_source_select;
        logic nine_bit_send_select;
        logic send_enable;
        logic sync_mode_select;
        logic unused;
        logic high_rate_select;
        logic shifter_empty_flag;
        logic send_ninth_bit;
    } tx_ctrl_s;
    typedef struct packed {
        logic serial_port_enable;
        logic nine_bit_receive_select;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic unused;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic received_ninth_bit;
    } rx_ctrl_s;
    typedef struct packed {
        logic out;
        logic oe_b;
    } pin_drive_s;
endpackage

// [core/serial_usart_ctrl_baud.sv]
// USART control/status registers, baud generator and serial engines.
// Assumes an Avalon-MM master on clock and a bench that resolves the pins.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "usart_consts.svh"

module serial_usart_ctrl_baud (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output      logic [31:0] readdata,
    output      logic        waitrequest,
    input  wire logic        serial_out_clock_pin_in,
    output      logic        serial_out_clock_pin_out,
    output      logic        serial_out_clock_pin_oe_b,
    input  wire logic        serial_in_data_pin_in,
    output      logic        serial_in_data_pin_out,
    output      logic        serial_in_data_pin_oe_b
);
    usart_pkg::tx_ctrl_s    tx_ctrl_ff;
    usart_pkg::rx_ctrl_s    rx_ctrl_ff;
    usart_pkg::link_state_e tx_state_ff;
    usart_pkg::link_state_e rx_state_ff;
    usart_pkg::pin_drive_s  ck_pin_ff;
    usart_pkg::pin_drive_s  dt_pin_ff;
    logic        wait_ff;
    logic [31:0] readdata_ff;
    logic [7:0]  rd_value;
    logic        wr_go;
    logic        rd_go;
    logic [7:0]  wdat;
    logic [7:0]  divisor_ff;
    logic [7:0]  brg_cnt_ff;
    logic [1:0]  port_dir_ff;
    logic        tick;
    logic [6:0]  ticks;
    logic        sync;
    logic        master;
    logic        port_on;
    logic        sync_rx;
    logic        rx_wants;
    logic        tx_go;
    logic [2:0]  ck_sync_ff;
    logic [2:0]  dt_sync_ff;
    logic        ck_flt_ff;
    logic        dt_flt_ff;
    logic        ck_prev_ff;
    logic [1:0]  sclk_cnt_ff;
    logic        sclk_run;
    logic        lead;
    logic        sample;
    logic [8:0]  tx_sh_ff;
    logic [3:0]  tx_idx_ff;
    logic [6:0]  tx_cnt_ff;
    logic        tx_line_ff;
    logic [7:0]  tx_data_ff;
    logic        tx_full_ff;
    logic        tx_step;
    logic        tx_last;
    logic        tx_load;
    logic [8:0]  rx_sh_ff;
    logic [3:0]  rx_idx_ff;
    logic [6:0]  rx_cnt_ff;
    logic [7:0]  rx_data_ff;
    logic        rx_full_ff;
    logic        rx_bit_end;
    logic        rx_half;
    logic        rx_last;
    logic        rx_done;
    logic        rx_bad;
    logic [8:0]  rx_next;
    logic [8:0]  rx_word;
    logic        full_eff;

    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_go && (address == ofs);
    endfunction

    function automatic logic [6:0] bit_ticks(input logic syn, input logic hi);
        bit_ticks = syn ? `TICKS_SYNC : (hi ? `TICKS_ASYNC_HI : `TICKS_ASYNC_LO);
    endfunction

    function automatic logic [3:0] last_idx(input logic nine);
        last_idx = (nine ? `BITS_WIDE : `BITS_NARROW) - 4'h1;
    endfunction

    // Bus answers one cycle after the request is seen
    assign wr_go = write & ~wait_ff & byteenable[0];
    assign rd_go = read & ~wait_ff;
    assign wdat  = writedata[7:0];

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wait_ff <= 1'b1;
        end else begin
            wait_ff <= ~((read | write) & wait_ff);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            readdata_ff <= 32'h0;
        end else if (read && wait_ff) begin
            readdata_ff <= {24'h0, rd_value};
        end
    end

    always_comb begin
        rd_value = 8'h00;
        case (address)
            `OFS_TX_CTRL: begin
                rd_value = tx_ctrl_ff;
                rd_value[1] = (tx_state_ff == usart_pkg::LINK_IDLE);
            end
            `OFS_RX_CTRL:  rd_value = rx_ctrl_ff;
            `OFS_DIVISOR:  rd_value = divisor_ff;
            `OFS_PORT_DIR: rd_value = {port_dir_ff, 6'h00};
            `OFS_RX_DATA:  rd_value = rx_data_ff;
            `OFS_STATUS:   rd_value = {6'h00, tx_full_ff, rx_full_ff};
            default:       rd_value = 8'h00;
        endcase
    end

    // Mode decode
    // Sync select
    assign sync     = tx_ctrl_ff.sync_mode_select;
    assign master   = sync & tx_ctrl_ff.clock_source_select;
    assign port_on  = rx_ctrl_ff.serial_port_enable & (&port_dir_ff);
    assign sync_rx  = sync & (rx_ctrl_ff.continuous_receive_enable
                              | (rx_ctrl_ff.single_receive_enable & master));
    assign rx_wants = port_on & ~rx_ctrl_ff.overrun_error_flag
                      & (sync ? sync_rx : rx_ctrl_ff.continuous_receive_enable);
    assign tx_go    = port_on & tx_ctrl_ff.send_enable & ~sync_rx;
    assign ticks    = bit_ticks(sync, tx_ctrl_ff.high_rate_select);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_ctrl_ff <= `TX_CTRL_RST & `TX_CTRL_WMASK;
        end else if (wr_hit(`OFS_TX_CTRL)) begin
            tx_ctrl_ff <= wdat & `TX_CTRL_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            port_dir_ff <= `PORT_DIR_RST;
        end else if (wr_hit(`OFS_PORT_DIR)) begin
            port_dir_ff <= wdat[7:6];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            divisor_ff <= `DIVISOR_RST;
        end else if (wr_hit(`OFS_DIVISOR)) begin
            divisor_ff <= wdat;
        end
    end

    assign tick = (brg_cnt_ff == divisor_ff);

    always_ff @(posedge clock) begin
        if (!rst_b || wr_hit(`OFS_DIVISOR) || tick) begin
            brg_cnt_ff <= 8'h00;
        end else begin
            brg_cnt_ff <= brg_cnt_ff + 8'h01;
        end
    end

    // Pin inputs: the first stage feeds only the second
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ck_sync_ff <= 3'h7;
            dt_sync_ff <= 3'h7;
            ck_flt_ff  <= 1'b1;
            dt_flt_ff  <= 1'b1;
            ck_prev_ff <= 1'b1;
        end else begin
            ck_sync_ff <= {ck_sync_ff[1:0], serial_out_clock_pin_in};
            dt_sync_ff <= {dt_sync_ff[1:0], serial_in_data_pin_in};
            if (ck_sync_ff[1] == ck_sync_ff[2]) begin
                ck_flt_ff <= ck_sync_ff[2];
            end
            if (dt_sync_ff[1] == dt_sync_ff[2]) begin
                dt_flt_ff <= dt_sync_ff[2];
            end
            ck_prev_ff <= ck_flt_ff;
        end
    end

    // Synchronous bit clock, low half then high half of each bit
    assign sclk_run = master & ((tx_state_ff != usart_pkg::LINK_IDLE)
                                | (rx_state_ff != usart_pkg::LINK_IDLE));

    always_ff @(posedge clock) begin
        if (!rst_b || !sclk_run) begin
            sclk_cnt_ff <= 2'h0;
        end else if (tick) begin
            sclk_cnt_ff <= sclk_cnt_ff + 2'h1;
        end
    end

    // Master uses the timer, slave the line clock
    assign lead   = master ? (tick && sclk_cnt_ff == `SCLK_FALL) : (~ck_flt_ff & ck_prev_ff);
    assign sample = master ? (tick && sclk_cnt_ff == `SCLK_RISE) : (ck_flt_ff & ~ck_prev_ff);

    // Transmit engine
    assign tx_step = sync ? lead : (tick && tx_cnt_ff == ticks - 7'h1);
    assign tx_last = (tx_idx_ff == last_idx(tx_ctrl_ff.nine_bit_send_select));
    // Async frames start on a tick so the start bit gets a whole bit time
    assign tx_load = port_on & (tx_state_ff == usart_pkg::LINK_IDLE) & tx_go & tx_full_ff & (sync | tick);

    always_ff @(posedge clock) begin
        if (!rst_b || tx_state_ff == usart_pkg::LINK_IDLE) begin
            tx_cnt_ff <= 7'h0;
        end else if (tick) begin
            tx_cnt_ff <= (tx_cnt_ff == ticks - 7'h1) ? 7'h0 : tx_cnt_ff + 7'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_state_ff <= usart_pkg::LINK_IDLE;
            tx_line_ff  <= 1'b1;
            tx_sh_ff    <= 9'h000;
            tx_idx_ff   <= 4'h0;
        end else if (!port_on) begin
            tx_state_ff <= usart_pkg::LINK_IDLE;
            tx_line_ff  <= 1'b1;
        end else begin
            unique case (tx_state_ff)
                usart_pkg::LINK_IDLE: begin
                    if (tx_load) begin
                        tx_sh_ff  <= {tx_ctrl_ff.send_ninth_bit, tx_data_ff};
                        tx_idx_ff <= 4'h0;
                        if (sync) begin
                            tx_state_ff <= usart_pkg::LINK_DATA;
                            tx_line_ff  <= tx_data_ff[0];
                        end else begin
                            tx_state_ff <= usart_pkg::LINK_START;
                            tx_line_ff  <= 1'b0;
                        end
                    end
                end
                usart_pkg::LINK_START: begin
                    if (tx_step) begin
                        tx_state_ff <= usart_pkg::LINK_DATA;
                        tx_line_ff  <= tx_sh_ff[0];
                    end
                end
                usart_pkg::LINK_DATA: begin
                    if (tx_step) begin
                        if (tx_last) begin
                            tx_state_ff <= sync ? usart_pkg::LINK_IDLE : usart_pkg::LINK_STOP;
                            tx_line_ff  <= 1'b1;
                        end else begin
                            tx_sh_ff   <= tx_sh_ff >> 1;
                            tx_line_ff <= tx_sh_ff[1];
                            tx_idx_ff  <= tx_idx_ff + 4'h1;
                        end
                    end
                end
                usart_pkg::LINK_STOP: begin
                    if (tx_step) begin
                        tx_state_ff <= usart_pkg::LINK_IDLE;
                    end
                end
            endcase
        end
    end

    // Holding register; a write in the load cycle still counts
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_data_ff <= 8'h00;
            tx_full_ff <= 1'b0;
        end else if (wr_hit(`OFS_TX_DATA)) begin
            tx_data_ff <= wdat;
            tx_full_ff <= 1'b1;
        end else if (tx_load) begin
            tx_full_ff <= 1'b0;
        end
    end

    // Receive engine
    assign rx_bit_end = tick && rx_cnt_ff == ticks - 7'h1;
    assign rx_half    = tick && rx_cnt_ff == (ticks >> 1) - 7'h1;
    assign rx_last    = (rx_idx_ff == last_idx(rx_ctrl_ff.nine_bit_receive_select));
    assign rx_next    = {dt_flt_ff, rx_sh_ff[8:1]};
    assign rx_done    = ((rx_state_ff == usart_pkg::LINK_STOP) & rx_bit_end)
                        | (sync & (rx_state_ff == usart_pkg::LINK_DATA) & sample & rx_last);
    assign rx_bad     = (rx_state_ff == usart_pkg::LINK_STOP) & ~dt_flt_ff;
    assign rx_word    = sync ? rx_next : rx_sh_ff;

    always_ff @(posedge clock) begin
        if (!rst_b || rx_state_ff == usart_pkg::LINK_IDLE
                   || (rx_state_ff == usart_pkg::LINK_START && rx_half)) begin
            rx_cnt_ff <= 7'h0;
        end else if (tick) begin
            rx_cnt_ff <= (rx_cnt_ff == ticks - 7'h1) ? 7'h0 : rx_cnt_ff + 7'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_state_ff <= usart_pkg::LINK_IDLE;
            rx_sh_ff    <= 9'h000;
            rx_idx_ff   <= 4'h0;
        end else if (!rx_wants) begin
            rx_state_ff <= usart_pkg::LINK_IDLE;
        end else begin
            unique case (rx_state_ff)
                usart_pkg::LINK_IDLE: begin
                    rx_idx_ff <= 4'h0;
                    if (sync) begin
                        rx_state_ff <= usart_pkg::LINK_DATA;
                    end else if (!dt_flt_ff) begin
                        rx_state_ff <= usart_pkg::LINK_START;
                    end
                end
                usart_pkg::LINK_START: begin
                    // Mid-start check rejects short glitches
                    if (rx_half) begin
                        rx_state_ff <= dt_flt_ff ? usart_pkg::LINK_IDLE : usart_pkg::LINK_DATA;
                    end
                end
                usart_pkg::LINK_DATA: begin
                    if (sync ? sample : rx_bit_end) begin
                        rx_sh_ff  <= rx_next;
                        rx_idx_ff <= rx_idx_ff + 4'h1;
                        if (rx_last) begin
                            rx_state_ff <= sync ? usart_pkg::LINK_IDLE : usart_pkg::LINK_STOP;
                        end
                    end
                end
                usart_pkg::LINK_STOP: begin
                    if (rx_bit_end) begin
                        rx_state_ff <= usart_pkg::LINK_IDLE;
                    end
                end
            endcase
        end
    end

    // A read in the completion cycle frees the slot for the new byte
    assign full_eff = rx_full_ff & ~(rd_go && address == `OFS_RX_DATA);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_data_ff <= 8'h00;
            rx_full_ff <= 1'b0;
        end else if (rx_done && !full_eff) begin
            rx_data_ff <= rx_ctrl_ff.nine_bit_receive_select ? rx_word[7:0] : rx_word[8:1];
            rx_full_ff <= 1'b1;
        end else if (!full_eff) begin
            rx_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_ctrl_ff <= `RX_CTRL_RST;
        end else begin
            if (wr_hit(`OFS_RX_CTRL)) begin
                rx_ctrl_ff[7:4] <= wdat[7:4];
            end else if (rx_done && master && !rx_ctrl_ff.continuous_receive_enable) begin
                rx_ctrl_ff.single_receive_enable <= 1'b0;
            end
            if (rx_done && !full_eff) begin
                rx_ctrl_ff.framing_error_flag <= rx_bad;
                rx_ctrl_ff.received_ninth_bit <= rx_word[8];
            end
            if (rx_done && full_eff) begin
                rx_ctrl_ff.overrun_error_flag <= 1'b1;
            end else if (wr_hit(`OFS_RX_CTRL) && !wdat[4]) begin
                rx_ctrl_ff.overrun_error_flag <= 1'b0;
            end
        end
    end

    // Pin drivers; both pins released while the port is off
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ck_pin_ff <= 2'h3;
            dt_pin_ff <= 2'h3;
        end else begin
            ck_pin_ff.out  <= sync ? sclk_cnt_ff[1] : tx_line_ff;
            ck_pin_ff.oe_b <= ~(port_on & (~sync | master));
            dt_pin_ff.out  <= tx_line_ff;
            dt_pin_ff.oe_b <= ~(port_on & sync & (tx_state_ff != usart_pkg::LINK_IDLE));
        end
    end

    assign readdata                  = readdata_ff;
    assign waitrequest               = wait_ff;
    assign serial_out_clock_pin_out  = ck_pin_ff.out;
    assign serial_out_clock_pin_oe_b = ck_pin_ff.oe_b;
    assign serial_in_data_pin_out    = dt_pin_ff.out;
    assign serial_in_data_pin_oe_b   = dt_pin_ff.oe_b;
endmodule // serial_usart_ctrl_baud

// [dv/usart_checker_assertions.sv]
// Bus and register checks on the USART control block ports.
// Assumes a master that holds each request until waitrequest is sampled low.
`timescale 1ns/1ps
`include "usart_consts.svh"
module usart_checker (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        serial_out_clock_pin_in,
    input wire logic        serial_out_clock_pin_out,
    input wire logic        serial_out_clock_pin_oe_b,
    input wire logic        serial_in_data_pin_in,
    input wire logic        serial_in_data_pin_out,
    input wire logic        serial_in_data_pin_oe_b
);
    logic [7:0] div_ff;
    logic [7:0] txc_ff;
    logic [7:0] rxc_ff;
    logic       wr_ok;
    logic       rq;
    assign wr_ok = write && !waitrequest && byteenable[0];
    assign rq    = read && waitrequest;
    always_ff @(posedge clock) begin
        if (!rst_b) div_ff <= `DIVISOR_RST;
        else if (wr_ok && address == `OFS_DIVISOR) div_ff <= writedata[7:0];
    end
    always_ff @(posedge clock) begin
        if (!rst_b) txc_ff <= `TX_CTRL_RST & `TX_CTRL_WMASK;
        else if (wr_ok && address == `OFS_TX_CTRL) txc_ff <= writedata[7:0] & `TX_CTRL_WMASK;
    end
    // Single receive may clear itself, so only the stable bits are compared
    always_ff @(posedge clock) begin
        if (!rst_b) rxc_ff <= `RX_CTRL_RST;
        else if (wr_ok && address == `OFS_RX_CTRL) rxc_ff <= writedata[7:0] & `RX_CTRL_WMASK;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wait_one_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    req_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in one cycle");
    upper_zero_a: assert property (readdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    reset_idle_a: assert property ($rose(rst_b) |-> waitrequest && serial_out_clock_pin_oe_b
        && serial_in_data_pin_oe_b && readdata == 32'h0) else $error("pins or bus not idle after reset");
    bit3_zero_a: assert property (rq && (address == `OFS_RX_CTRL || address == `OFS_TX_CTRL)
        |=> !readdata[3]) else $error("unimplemented control bit reads one");
    div_read_a: assert property (rq && address == `OFS_DIVISOR |=> readdata[7:0] == div_ff)
        else $error("divisor readback differs from last write");
    txc_read_a: assert property (rq && address == `OFS_TX_CTRL
        |=> (readdata[7:0] & `TX_CTRL_WMASK) == txc_ff) else $error("transmit control readback wrong");
    rxc_read_a: assert property (rq && address == `OFS_RX_CTRL
        |=> {readdata[7:6], readdata[4]} == {rxc_ff[7:6], rxc_ff[4]}) else $error("receive control readback wrong");
    read_hold_a: assert property (!rq |=> $stable(readdata))
        else $error("read data changed without a read");
    cover property (rq && address == `OFS_DIVISOR);
    cover property (wr_ok && address == `OFS_TX_DATA);
    cover property ($fell(serial_in_data_pin_in));
    cover property (!serial_in_data_pin_oe_b);
endmodule // usart_checker
bind serial_usart_ctrl_baud usart_checker chk_i (
    .clock(clock), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .serial_out_clock_pin_in(serial_out_clock_pin_in), .serial_out_clock_pin_out(serial_out_clock_pin_out),
    .serial_out_clock_pin_oe_b(serial_out_clock_pin_oe_b), .serial_in_data_pin_in(serial_in_data_pin_in),
    .serial_in_data_pin_out(serial_in_data_pin_out), .serial_in_data_pin_oe_b(serial_in_data_pin_oe_b));

// [dv/serial_peer.sv]
// Asynchronous serial peer: sends frames and captures frames on the line.
// Assumes the bench resolves the pins; the receive line idles high.
`timescale 1ns/1ps
module serial_peer (
    input  wire logic clock,
    input  wire logic tx_line,
    output      logic rx_drive
);
    initial rx_drive = 1'b1;
    task automatic send(input logic [8:0] d, input int nb, input int bc, input logic stp);
        @(posedge clock);
        rx_drive <= 1'b0;
        repeat (bc) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            rx_drive <= d[i];
            repeat (bc) @(posedge clock);
        end
        rx_drive <= stp;
        repeat (bc) @(posedge clock);
        rx_drive <= 1'b1;
        repeat (bc) @(posedge clock);
    endtask
    // Low run measured from the start edge; data bit 0 must be one for it to be exact
    task automatic grab(input int nb, input int bc, output logic [8:0] d, output int low, output logic stp);
        d   = 9'h000;
        low = 0;
        while (tx_line !== 1'b0) @(posedge clock);
        while (tx_line === 1'b0) begin
            low++;
            @(posedge clock);
        end
        repeat (bc / 2) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            d[i] = tx_line;
            repeat (bc) @(posedge clock);
        end
        stp = tx_line;
    endtask
endmodule // serial_peer

// [dv/testbench.sv]
// Self-checking bench for the USART control block with a serial peer.
// Assumes a pull-up on both pins while no party drives them.
`timescale 1ns/1ps
`include "usart_consts.svh"
module testbench;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [3:0] be; logic [7:0] e;} row_s;
    typedef struct packed {logic [7:0] c; logic [7:0] dv; int nb; int bc; logic [8:0] e;} txr_s;
    logic        clock, rst_b, read, write, waitrequest, rx_drive, stp;
    logic        so_out, so_oe_b, si_out, si_oe_b;
    logic [7:0]  address, q;
    logic [8:0]  got;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable;
    int          err_total, check_count, low;
    wire         tx_line = so_oe_b ? 1'b1 : so_out;
    wire         rx_line = si_oe_b ? rx_drive : si_out;
    row_s rows [6] = '{'{`OFS_RX_CTRL, 8'h4F, 4'hF, 8'h40}, '{`OFS_TX_CTRL, 8'h0F, 4'hF, 8'h07},
        '{`OFS_DIVISOR, 8'hFF, 4'hF, 8'hFF}, '{`OFS_DIVISOR, 8'h00, 4'hF, 8'h00},
        '{`OFS_DIVISOR, 8'h33, 4'h0, 8'h00}, '{8'h04, 8'h5A, 4'hF, 8'h00}};
    // slow row keeps high rate clear
    txr_s txr [3] = '{'{8'h24, 8'h00, 8, 16, 9'h0A5}, '{8'h65, 8'h00, 9, 16, 9'h1A5},
        '{8'h20, 8'h01, 8, 128, 9'h0A5}};
    serial_usart_ctrl_baud dut (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .serial_out_clock_pin_in(tx_line), .serial_out_clock_pin_out(so_out),
        .serial_out_clock_pin_oe_b(so_oe_b), .serial_in_data_pin_in(rx_line),
        .serial_in_data_pin_out(si_out), .serial_in_data_pin_oe_b(si_oe_b));
    serial_peer peer (.clock(clock), .tx_line(tx_line), .rx_drive(rx_drive));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] be);
        @(posedge clock);
        address    <= a;
        write      <= w;
        read       <= !w;
        writedata  <= {24'h0, d};
        byteenable <= be;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'hF);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, 4'hF);
        chk(32'(q & m), 32'(e));
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end
    initial begin
        {rst_b, read, write, address, writedata, byteenable} = '0;
        err_total   = 0;
        check_count = 0;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        chk(32'({so_oe_b, si_oe_b}), 32'h3);
        rc(`OFS_TX_CTRL, 8'hFF, 8'h02);
        rc(`OFS_RX_CTRL, 8'hFE, 8'h00);
        rc(`OFS_DIVISOR, 8'hFF, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            bus(rows[i].a, 1'b1, rows[i].d, rows[i].be);
            rc(rows[i].a, 8'hFF, rows[i].e);
        end
        $display("test register table done");
        wr(`OFS_RX_CTRL, 8'h80);
        foreach (txr[i]) begin
            wr(`OFS_DIVISOR, txr[i].dv);
            wr(`OFS_TX_CTRL, txr[i].c);
            fork
                peer.grab(txr[i].nb, txr[i].bc, got, low, stp);
                begin
                    wr(`OFS_TX_DATA, 8'hA5);
                    repeat (4) @(posedge clock);
                    rc(`OFS_TX_CTRL, 8'h02, 8'h00);
                end
            join
            chk(32'(got), 32'(txr[i].e));
            chk(32'(low), 32'(txr[i].bc));
            chk(32'(stp), 32'h1);
            repeat (txr[i].bc) @(posedge clock);
            rc(`OFS_TX_CTRL, 8'h02, 8'h02);
        end
        $display("test transmit done");
        wr(`OFS_DIVISOR, 8'h00);
        wr(`OFS_TX_CTRL, 8'h24);
        wr(`OFS_RX_CTRL, 8'h90);
        peer.send(9'h03C, 8, 16, 1'b1);
        repeat (20) @(posedge clock);
        rc(`OFS_STATUS, 8'h01, 8'h01);
        rc(`OFS_RX_DATA, 8'hFF, 8'h3C);
        peer.send(9'h00F, 8, 16, 1'b0);
        repeat (20) @(posedge clock);
        rc(`OFS_RX_CTRL, 8'h04, 8'h04);
        rc(`OFS_RX_DATA, 8'hFF, 8'h0F);
        peer.send(9'h03C, 8, 16, 1'b1);
        peer.send(9'h055, 8, 16, 1'b1);
        repeat (20) @(posedge clock);
        rc(`OFS_RX_CTRL, 8'h06, 8'h02);
        wr(`OFS_RX_CTRL, 8'h80);
        rc(`OFS_RX_CTRL, 8'h02, 8'h00);
        rc(`OFS_RX_DATA, 8'hFF, 8'h3C);
        wr(`OFS_RX_CTRL, 8'hD0);
        peer.send(9'h1C3, 9, 16, 1'b1);
        repeat (20) @(posedge clock);
        rc(`OFS_RX_CTRL, 8'h01, 8'h01);
        rc(`OFS_RX_DATA, 8'hFF, 8'hC3);
        $display("test receive done");
        // Synchronous master send: data sampled at each rising edge of the clock pin
        wr(`OFS_RX_CTRL, 8'h80);
        wr(`OFS_TX_CTRL, 8'hB0);
        wr(`OFS_TX_DATA, 8'h5A);
        for (int i = 0; i < 8; i++) begin
            @(posedge so_out);
            got[i] = si_out;
        end
        chk(32'(si_oe_b), 32'h0);
        chk(32'(got[7:0]), 32'h5A);
        repeat (20) @(posedge clock);
        rc(`OFS_TX_CTRL, 8'h12, 8'h12);
        $display("test synchronous send done");
        chk(32'(so_oe_b), 32'h0);
        wr(`OFS_PORT_DIR, 8'h40);
        repeat (4) @(posedge clock);
        chk(32'({so_oe_b, si_oe_b}), 32'h3);
        $display("test port routing done");
        tally_and_finish();
    end
endmodule // testbench
